/* File: rtl/rtc_calendar.sv */
// BCD time and calendar counter with alarm, tick, clock output and spare storage
`timescale 1ns/1ps
module rtc_calendar (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [rtc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [rtc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [rtc_pkg::DATA_W-1:0] rdata_o,
    input wire logic slow_xtal_in_pin_i,
    output logic slow_xtal_out_pin_o,
    input wire logic snoop_i,
    output logic irq_o,
    output logic wake_o,
    output logic slow_clock_out_o
);
    import rtc_pkg::*;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v == 8'h99) begin
            bcd_inc = 8'h00;
        end else if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = v + 8'h01;
        end
    endfunction

    function automatic logic [5:0] days_in(input logic [4:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            5'h02: days_in = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: days_in = 6'h30;
            default: days_in = 6'h31;
        endcase
    endfunction

    function automatic logic [31:0] pack_time(input logic [5:0] h, input logic [6:0] m,
                                              input logic [6:0] s);
        pack_time = {10'h0, h, 1'b0, m, 1'b0, s};
    endfunction

    function automatic logic [31:0] pack_cal(input logic [7:0] y, input logic [4:0] m,
                                             input logic [5:0] d);
        pack_cal = {8'h0, y, 3'h0, m, 2'h0, d};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic xin_q;
    logic [15:0] presc;
    logic [6:0] sec, min;
    logic [5:0] hour, day;
    logic [4:0] mon;
    logic [7:0] year;
    logic [2:0] dow;
    logic [6:0] a_sec, a_min;
    logic [5:0] a_hour, a_day;
    logic [4:0] a_mon;
    logic [7:0] a_year;
    logic hour_24;
    logic [2:0] tick_period_sel;
    logic tick_wake_enable;
    logic [7:0] freq_comp;
    logic [2:0] clkout_sel;
    logic [1:0] irq_enable;
    logic [1:0] irq_status;
    logic [3:0] half_cnt;
    logic sec_upd;
    logic [31:0] spare [SPARE_WORDS];
    logic [DATA_W-1:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // Timebase events
    logic xedge, sec_evt, tick_evt, half_evt;
    logic [15:0] presc_end, tmask;
    logic [3:0] cmask;
    logic [2:0] csel;
    logic wr_time, wr_cal;
    logic wr_atime, wr_acal, wr_ctrl, wr_dow, wr_tick;
    logic wr_fcomp, wr_clkout, wr_ien, wr_iclr;
    assign wr_time = wr_i && addr_i == TIME_OFS;
    assign wr_cal = wr_i && addr_i == CAL_OFS;
    assign wr_atime = wr_i && addr_i == ATIME_OFS;
    assign wr_acal = wr_i && addr_i == ACAL_OFS;
    assign wr_ctrl = wr_i && addr_i == CTRL_OFS;
    assign wr_dow = wr_i && addr_i == DOW_OFS;
    assign wr_tick = wr_i && addr_i == TICK_OFS;
    assign wr_fcomp = wr_i && addr_i == FCOMP_OFS;
    assign wr_clkout = wr_i && addr_i == CLKOUT_OFS;
    assign wr_ien = wr_i && addr_i == IEN_OFS;
    assign wr_iclr = wr_i && addr_i == ICLR_OFS;
    assign xedge = slow_xtal_in_pin_i && !xin_q;
    assign presc_end = PRESC_LAST + {{8{freq_comp[7]}}, freq_comp};
    assign sec_evt = xedge && presc >= presc_end;
    assign tmask = 16'((TICK_BASE << tick_period_sel) - 16'h1);
    assign tick_evt = (tick_period_sel == 3'h7) ? sec_evt
                    : xedge && (presc & tmask) == tmask;
    assign half_evt = xedge && presc[13:0] == HALF_MASK;
    assign csel = (clkout_sel > CLKOUT_MAX) ? CLKOUT_MAX : clkout_sel;
    assign cmask = 4'((5'h01 << csel) - 5'h01);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            xin_q <= 1'b0;
            slow_xtal_out_pin_o <= 1'b0;
        end else begin
            xin_q <= slow_xtal_in_pin_i;
            slow_xtal_out_pin_o <= !slow_xtal_in_pin_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || wr_time) begin
            presc <= 16'h0;
        end else if (sec_evt) begin
            presc <= 16'h0;
        end else if (xedge) begin
            presc <= presc + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next time and calendar values
    logic [6:0] next_sec, next_min;
    logic [5:0] next_hour, next_day;
    logic [4:0] next_mon;
    logic [7:0] next_year;
    logic day_roll;

    always_comb begin
        next_sec = 7'(bcd_inc({1'b0, sec}));
        next_min = min;
        next_hour = hour;
        day_roll = 1'b0;
        if (sec == 7'h59) begin
            next_sec = 7'h00;
            next_min = 7'(bcd_inc({1'b0, min}));
            if (min == 7'h59) begin
                next_min = 7'h00;
                if (hour_24) begin
                    next_hour = 6'(bcd_inc({2'b00, hour}));
                    if (hour == 6'h23) begin
                        next_hour = 6'h00;
                        day_roll = 1'b1;
                    end
                end else if (hour[4:0] == 5'h12) begin
                    next_hour = {hour[HOUR_PM_BIT], 5'h01};
                end else if (hour[4:0] == 5'h11) begin
                    next_hour = {!hour[HOUR_PM_BIT], 5'h12};
                    day_roll = hour[HOUR_PM_BIT];
                end else begin
                    next_hour = {hour[HOUR_PM_BIT], 5'(bcd_inc({3'b000, hour[4:0]}))};
                end
            end
        end
    end

    always_comb begin
        next_day = 6'(bcd_inc({2'b00, day}));
        next_mon = mon;
        next_year = year;
        if (day == days_in(mon, year)) begin
            next_day = DAY_RST;
            next_mon = 5'(bcd_inc({3'b000, mon}));
            if (mon == 5'h12) begin
                next_mon = MON_RST;
                next_year = bcd_inc(year);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time and calendar counters
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sec <= 7'h00;
            min <= 7'h00;
            hour <= 6'h00;
        end else if (wr_time) begin
            sec <= wdata_i[6:0];
            min <= wdata_i[MIN_LSB +: 7];
            hour <= wdata_i[HOUR_LSB +: 6];
        end else if (sec_evt) begin
            sec <= next_sec;
            min <= next_min;
            hour <= next_hour;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            day <= DAY_RST;
            mon <= MON_RST;
            year <= YEAR_RST;
        end else if (wr_cal) begin
            day <= wdata_i[5:0];
            mon <= wdata_i[MON_LSB +: 5];
            year <= wdata_i[YEAR_LSB +: 8];
        end else if (sec_evt && day_roll) begin
            day <= next_day;
            mon <= next_mon;
            year <= next_year;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            dow <= 3'h0;
        end else if (wr_dow) begin
            dow <= wdata_i[2:0];
        end else if (sec_evt && day_roll) begin
            dow <= (dow >= DOW_LAST) ? 3'h0 : dow + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm and control registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            a_sec <= 7'h00;
            a_min <= 7'h00;
            a_hour <= 6'h00;
            a_day <= DAY_RST;
            a_mon <= MON_RST;
            a_year <= YEAR_RST;
        end else if (wr_atime) begin
            a_sec <= wdata_i[6:0];
            a_min <= wdata_i[MIN_LSB +: 7];
            a_hour <= wdata_i[HOUR_LSB +: 6];
        end else if (wr_acal) begin
            a_day <= wdata_i[5:0];
            a_mon <= wdata_i[MON_LSB +: 5];
            a_year <= wdata_i[YEAR_LSB +: 8];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            hour_24 <= 1'b1;
        end else if (wr_ctrl) begin
            hour_24 <= wdata_i[0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tick_period_sel <= 3'h0;
            tick_wake_enable <= 1'b0;
        end else if (wr_tick) begin
            tick_period_sel <= wdata_i[2:0];
            tick_wake_enable <= wdata_i[TICK_WAKE_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            freq_comp <= 8'h00;
        end else if (wr_fcomp) begin
            freq_comp <= wdata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            clkout_sel <= 3'h0;
        end else if (wr_clkout) begin
            clkout_sel <= wdata_i[2:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_enable <= 2'b00;
        end else if (wr_ien) begin
            irq_enable <= wdata_i[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags, interrupt and wake-up
    logic alarm_hit;
    assign alarm_hit = sec_upd && sec == a_sec && min == a_min && hour == a_hour
                       && day == a_day && mon == a_mon && year == a_year;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sec_upd <= 1'b0;
        end else begin
            sec_upd <= sec_evt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_status <= 2'b00;
        end else begin
            if (wr_iclr) begin
                irq_status <= irq_status & ~wdata_i[1:0];
            end
            if (alarm_hit) begin
                irq_status[ALARM_BIT] <= 1'b1;
            end
            if (tick_evt) begin
                irq_status[TICK_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_enable);
            wake_o <= irq_status[ALARM_BIT]
                      || (irq_status[TICK_BIT] && tick_wake_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow clock output
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            half_cnt <= 4'h0;
            slow_clock_out_o <= 1'b0;
        end else if (half_evt) begin
            half_cnt <= half_cnt + 4'h1;
            if ((half_cnt & cmask) == cmask) begin
                slow_clock_out_o <= !slow_clock_out_o;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Spare storage
    logic spare_hit;
    logic [4:0] spare_idx;
    assign spare_hit = addr_i >= SPARE_OFS && addr_i < SPARE_END && addr_i[1:0] == 2'b00;
    assign spare_idx = 5'((addr_i - SPARE_OFS) >> 2);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || snoop_i) begin
            for (int i = 0; i < SPARE_WORDS; i++) begin
                spare[i] <= 32'h0;
            end
        end else if (wr_i && spare_hit) begin
            spare[spare_idx] <= wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        rd_val = '0;
        case (addr_i)
            TIME_OFS: rd_val = pack_time(hour, min, sec);
            CAL_OFS: rd_val = pack_cal(year, mon, day);
            ATIME_OFS: rd_val = pack_time(a_hour, a_min, a_sec);
            ACAL_OFS: rd_val = pack_cal(a_year, a_mon, a_day);
            CTRL_OFS: rd_val = {31'h0, hour_24};
            DOW_OFS: rd_val = {29'h0, dow};
            TICK_OFS: rd_val = {28'h0, tick_wake_enable, tick_period_sel};
            FCOMP_OFS: rd_val = {24'h0, freq_comp};
            CLKOUT_OFS: rd_val = {29'h0, clkout_sel};
            IEN_OFS: rd_val = {30'h0, irq_enable};
            ISTAT_OFS: rd_val = {30'h0, irq_status};
            default: rd_val = (spare_hit && !snoop_i) ? spare[spare_idx] : '0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rd_i ? rd_val : '0;
        end
    end
endmodule // rtc_calendar

/* File: rtl/rtc_pkg.sv */
// Constants, register map and field layout of the BCD calendar clock
package rtc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] TIME_OFS = 8'h00;
    localparam logic [7:0] CAL_OFS = 8'h04;
    localparam logic [7:0] ATIME_OFS = 8'h08;
    localparam logic [7:0] ACAL_OFS = 8'h0c;
    localparam logic [7:0] CTRL_OFS = 8'h10;
    localparam logic [7:0] DOW_OFS = 8'h14;
    localparam logic [7:0] TICK_OFS = 8'h18;
    localparam logic [7:0] FCOMP_OFS = 8'h1c;
    localparam logic [7:0] CLKOUT_OFS = 8'h20;
    localparam logic [7:0] IEN_OFS = 8'h24;
    localparam logic [7:0] ISTAT_OFS = 8'h28;
    localparam logic [7:0] ICLR_OFS = 8'h2c;
    localparam logic [7:0] SPARE_OFS = 8'h40;
    localparam int SPARE_WORDS = 20;
    localparam logic [7:0] SPARE_END = 8'h90;
    // Field positions
    localparam int MIN_LSB = 8;
    localparam int HOUR_LSB = 16;
    localparam int MON_LSB = 8;
    localparam int YEAR_LSB = 16;
    localparam int HOUR_PM_BIT = 5;
    localparam int ALARM_BIT = 0;
    localparam int TICK_BIT = 1;
    localparam int TICK_WAKE_BIT = 3;
    // Reset values and last day of week
    localparam logic [5:0] DAY_RST = 6'h01;
    localparam logic [4:0] MON_RST = 5'h01;
    localparam logic [7:0] YEAR_RST = 8'h00;
    localparam logic [2:0] DOW_LAST = 3'h6;
    // Timebase
    localparam int XTAL_HZ = 32768;
    localparam logic [15:0] PRESC_LAST = 16'(XTAL_HZ - 1);
    localparam logic [15:0] TICK_BASE = 16'(XTAL_HZ / 128);
    localparam logic [13:0] HALF_MASK = 14'(XTAL_HZ / 2 - 1);
    localparam logic [2:0] CLKOUT_MAX = 3'h4;
endpackage

/* File: test/xtal_source_model.sv */
// Behavioural slow crystal source for the calendar clock
`timescale 1ns/1ps
module xtal_source_model #(
    parameter int HALF = 1
) (
    input wire logic clk_i,
    output logic xtal_o
);
    int cnt = 0;
    logic level = 1'b0;
    assign xtal_o = level;
    // Free-running square wave, one rising edge per source period
    always @(posedge clk_i) begin
        if (cnt == HALF - 1) begin
            cnt <= 0;
            level <= ~level;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // xtal_source_model

/* File: test/rtc_calendar_monitor.sv */
// Port checker of the calendar clock
`timescale 1ns/1ps
module rtc_calendar_monitor (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [rtc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [rtc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [rtc_pkg::DATA_W-1:0] rdata_o,
    input wire logic slow_xtal_in_pin_i,
    input wire logic slow_xtal_out_pin_o,
    input wire logic snoop_i,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic slow_clock_out_o
);
    import rtc_pkg::*;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    logic spare_a;
    logic bad_a;
    assign spare_a = addr_i >= SPARE_OFS && addr_i < SPARE_END && addr_i[1:0] == 2'h0;
    assign bad_a = addr_i[1:0] != 2'h0 || (addr_i > ICLR_OFS && addr_i < SPARE_OFS);
    ////////////////////////////////////////////////////////////////
    sequence s_spare_wr;
        wr_i && spare_a && !snoop_i;
    endsequence
    sequence s_same_rd;
        rd_i && !snoop_i && addr_i == $past(addr_i);
    endsequence
    sequence s_en_off;
        wr_i && addr_i == IEN_OFS && wdata_i[1:0] == 2'h0;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == '0)
        else $error("read data not zero outside read");
    a_spare_echo: assert property (s_spare_wr ##1 s_same_rd |=> rdata_o == $past(wdata_i, 2))
        else $error("spare word read back wrong");
    a_snoop_clears: assert property (snoop_i && rd_i && spare_a |=> rdata_o == '0)
        else $error("spare word not cleared by snoop");
    a_unmapped_zero: assert property (rd_i && (bad_a || addr_i >= SPARE_END) |=> rdata_o == '0)
        else $error("unmapped read not zero");
    a_iclr_reads_zero: assert property (rd_i && addr_i == ICLR_OFS |=> rdata_o == '0)
        else $error("clear register read not zero");
    a_time_bcd: assert property (rd_i && addr_i == TIME_OFS |=> rdata_o[3:0] <= 4'h9 && rdata_o[6:4] <= 3'h5 && rdata_o[11:8] <= 4'h9 && rdata_o[14:12] <= 3'h5)
        else $error("time not in bcd");
    a_dow_range: assert property (rd_i && addr_i == DOW_OFS |=> rdata_o <= 32'h6)
        else $error("day of week out of range");
    a_irq_en_off: assert property (s_en_off ##1 !(wr_i && addr_i == IEN_OFS) |=> !irq_o)
        else $error("interrupt high with enables cleared");
    a_xtal_inverse: assert property (!$past(srst_i) && !$past(srst_i, 2) |-> slow_xtal_out_pin_o == !$past(slow_xtal_in_pin_i))
        else $error("crystal output not inverse of input");
    a_clkout_hold: assert property ($changed(slow_clock_out_o) |=> $stable(slow_clock_out_o) [*8])
        else $error("clock output toggles too fast");
endmodule // rtc_calendar_monitor
bind rtc_calendar rtc_calendar_monitor rtc_calendar_monitor_inst (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slow_xtal_in_pin_i(slow_xtal_in_pin_i),
    .slow_xtal_out_pin_o(slow_xtal_out_pin_o), .snoop_i(snoop_i), .irq_o(irq_o),
    .wake_o(wake_o), .slow_clock_out_o(slow_clock_out_o));

/* File: test/bcd_calendar_clock_alarm_bench.sv */
// Self-checking bench of the calendar clock
`timescale 1ns/1ps
module bcd_calendar_clock_alarm_bench;
    import rtc_pkg::*;
    logic sys_clk_i;
    logic srst_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [DATA_W-1:0] rdata_o;
    logic xin;
    logic xout;
    logic snoop_i;
    logic irq_o;
    logic wake_o;
    logic clk_out;
    logic pc;
    logic [31:0] v;
    logic [7:0] ra [12];
    logic [31:0] rv [12];
    int n_mismatch;
    int comparisons;
    int n;
    int tog;
    time t0;
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    rtc_calendar rtc_calendar_inst (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slow_xtal_in_pin_i(xin),
        .slow_xtal_out_pin_o(xout), .snoop_i(snoop_i), .irq_o(irq_o), .wake_o(wake_o),
        .slow_clock_out_o(clk_out));
    xtal_source_model xtal_source_model_inst (.clk_i(sys_clk_i), .xtal_o(xin));
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] bcd(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction
    task automatic finish_test();
        $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= x;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_irq(input int lim);
        n = 0;
        tog = 0;
        pc = clk_out;
        while (irq_o !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
            if (clk_out !== pc) tog++;
            pc = clk_out;
        end
        if (n >= lim) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        srst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        snoop_i = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(32'h484ce38e));
        repeat (12) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        #1;
        ra = '{TIME_OFS, CAL_OFS, ACAL_OFS, CTRL_OFS, DOW_OFS, TICK_OFS, FCOMP_OFS,
            ISTAT_OFS, ICLR_OFS, SPARE_OFS, 8'h30, 8'h42};
        rv = '{0, 32'h101, 32'h101, 1, 0, 0, 0, 0, 0, 0, 0, 0};
        for (int i = 0; i < 12; i++) begin
            rchk(ra[i], rv[i]);
        end
        pc = xin;
        cyc(1);
        chk(xout, !pc);
        // Random loads of time, calendar and both alarm words
        for (int i = 0; i < 4; i++) begin
            v = {8'h0, bcd($urandom % 24), bcd($urandom % 60), bcd($urandom % 60)};
            if (i % 2 == 1) v = {8'h0, bcd($urandom % 100), bcd($urandom % 12 + 1),
                bcd($urandom % 28 + 1)};
            wr(8'(i * 4), v);
            rchk(8'(i * 4), v);
        end
        for (int i = 0; i < SPARE_WORDS; i++) begin
            v = $urandom;
            wr(8'(SPARE_OFS + i * 4), v);
            rchk(8'(SPARE_OFS + i * 4), v);
        end
        snoop_i <= 1'b1;
        rchk(8'(SPARE_OFS + 4), 0);
        rchk(SPARE_OFS, 0);
        snoop_i <= 1'b0;
        cyc(1);
        rchk(8'(SPARE_END - 4), 0);
        v = $urandom;
        wr(FCOMP_OFS, {24'h0, v[7:0]});
        rchk(FCOMP_OFS, {24'h0, v[7:0]});
        wr(FCOMP_OFS, 0);
        // Tick periods, wake gating and sticky tick flag
        wr(IEN_OFS, 32'h2);
        for (int k = 0; k < 3; k++) begin
            wr(TICK_OFS, {28'h0, k[1], 3'(k)});
            wr(ICLR_OFS, 32'h2);
            cyc(2);
            wait_irq(5000);
            t0 = $time;
            wr(ICLR_OFS, 32'h2);
            cyc(2);
            wait_irq(5000);
            chk(32'(($time - t0) / 8), 32'(512 << k));
            chk(wake_o, k[1]);
        end
        wr(TICK_OFS, 32'h7);
        wr(IEN_OFS, 0);
        cyc(2);
        chk(irq_o, 0);
        rchk(ISTAT_OFS, 32'h2);
        wr(ICLR_OFS, 32'h2);
        rchk(ISTAT_OFS, 0);
        // One second across midnight from February 28 of a leap year, 12-hour mode
        wr(CTRL_OFS, 0);
        rchk(CTRL_OFS, 0);
        wr(CAL_OFS, 32'h0004_0228);
        wr(ACAL_OFS, 32'h0004_0229);
        wr(ATIME_OFS, 32'h0012_0000);
        wr(DOW_OFS, 6);
        wr(CLKOUT_OFS, 0);
        wr(IEN_OFS, 1);
        wr(TIME_OFS, 32'h0031_5959);
        wait_irq(70000);
        chk(n > 65530 && n < 65545, 1);
        chk(tog, 2);
        chk(wake_o, 1);
        rchk(TIME_OFS, 32'h0012_0000);
        rchk(CAL_OFS, 32'h0004_0229);
        rchk(DOW_OFS, 0);
        rchk(ISTAT_OFS, 32'h3);
        finish_test();
    end
endmodule // bcd_calendar_clock_alarm_bench
